// ==== uesr_status_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module uesr_status_regs
   import uesr_pkg::*;
#(
   parameter int IDLE_CYC = UESR_IDLE_CYC,
   parameter int SUSP_CYC = UESR_SUSP_CYC
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_sys_rst,
   // Register bus
   input  wire uesr_bus_req_type i_bus,
   output logic [7:0]            o_rdata,
   // Core events
   input  wire uesr_evt_type     i_evt,
   input  wire logic             i_core_reset,
   input  wire logic             i_bus_idle,
   input  wire logic             i_bus_status_mask,
   // Endpoint interrupt sources, index 2n read, 2n+1 write
   input  wire logic [7:0]       i_ep_irq_raw,
   input  wire logic [7:0]       i_ep_irq_en,
   // Read FIFO
   input  wire logic [4:0]       i_fifo_free_words,
   input  wire logic [4:0]       i_buf_len_words,
   input  wire logic             i_buf_last,
   output logic                  o_prefetch_req,
   // Control endpoint actions
   output logic                  o_ep0_disable,
   output logic                  o_control_out_flush,
   output logic                  o_control_in_flush,
   output logic                  o_endpoint_flush_flag,
   // PHY
   output logic                  o_phy_fs,
   // Interrupt controller
   output logic                  o_top_bus_status,
   output logic [7:0]            o_src_irq,
   output logic [7:0]            o_endpoint_irq_group
);

   // ******************************
   // Storage
   // ******************************
   logic [3:0] thresh_r;
   logic [7:0] busst_r;
   logic [7:0] src_r;
   logic [7:0] src_nxt;
   logic [7:0] epsum_r;
   logic       core_reset_d_r;
   logic       setup_rearm_r;
   logic       phy_fs_w;
   logic       suspend_pulse;
   logic [4:0] trip_level;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      return a == off;
   endfunction

   // ******************************
   // Suspend timer
   // ******************************
   uesr_suspend_timer #(
      .IDLE_CYC (IDLE_CYC),
      .SUSP_CYC (SUSP_CYC)
   ) u_susp (
      .i_clk_sys       (i_clk_sys),
      .i_sys_rst       (i_sys_rst),
      .i_bus_idle      (i_bus_idle),
      .o_phy_fs        (phy_fs_w),
      .o_suspend_pulse (suspend_pulse)
   );

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_phy_fs <= 1'b0;
      end else begin
         o_phy_fs <= phy_fs_w;
      end
   end

   // ******************************
   // Prefetch threshold
   // ******************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         thresh_r <= UESR_THRESH_RST;
      end else if (i_bus.wr && hit(i_bus.addr, UESR_OFF_THRESH)) begin
         thresh_r <= i_bus.wdata[3:0];
      end
   end

   assign trip_level = {1'b0, thresh_r} + 5'h1;

   // Short last buffer cannot ever fill the trip level, so it goes at once
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_prefetch_req <= 1'b0;
      end else if (i_buf_last && (i_buf_len_words < trip_level)) begin
         o_prefetch_req <= 1'b1;
      end else begin
         o_prefetch_req <= (i_fifo_free_words >= trip_level);
      end
   end

   // ******************************
   // Bus status
   // ******************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         core_reset_d_r <= 1'b0;
      end else begin
         core_reset_d_r <= i_core_reset;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         busst_r <= UESR_ZERO8;
      end else begin
         busst_r[7:1] <= 7'h00;
         if (core_reset_d_r && !i_core_reset) begin
            busst_r[UESR_BUSRST_BIT] <= 1'b1;
         end else if (i_bus.wr && hit(i_bus.addr, UESR_OFF_BUSST)
                      && i_bus.wdata[UESR_BUSRST_BIT]) begin
            busst_r[UESR_BUSRST_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_top_bus_status <= 1'b0;
      end else begin
         o_top_bus_status <= busst_r[UESR_BUSRST_BIT] & ~i_bus_status_mask;
      end
   end

   // ******************************
   // Protocol event source
   // ******************************
   always_comb begin
      src_nxt = src_r;
      if (i_bus.wr && hit(i_bus.addr, UESR_OFF_SRC)) begin
         src_nxt = src_r & ~i_bus.wdata;
      end
      if (i_evt.halt_clear) begin
         src_nxt[UESR_HALT_BIT] = 1'b1;
      end
      if (i_evt.config_set) begin
         src_nxt[UESR_CONF_BIT] = 1'b1;
      end
      if (suspend_pulse) begin
         src_nxt[UESR_SUSP_BIT] = 1'b1;
      end
      if (i_evt.intf_set) begin
         src_nxt[UESR_INTF_BIT] = 1'b1;
      end
      // A repeat setup shows as one low cycle so the edge is seen again
      if (i_evt.setup_rx) begin
         src_nxt[UESR_SETUP_BIT] = ~src_r[UESR_SETUP_BIT];
      end else if (src_r[UESR_SETUP_BIT] == 1'b0 && setup_rearm_r) begin
         src_nxt[UESR_SETUP_BIT] = 1'b1;
      end
      src_nxt = src_nxt & UESR_SRC_MASK;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         setup_rearm_r <= 1'b0;
      end else begin
         setup_rearm_r <= i_evt.setup_rx && src_r[UESR_SETUP_BIT];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         src_r     <= UESR_ZERO8;
         o_src_irq <= UESR_ZERO8;
      end else begin
         src_r     <= src_nxt;
         o_src_irq <= src_nxt;
      end
   end

   // ******************************
   // Setup side effects
   // ******************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_ep0_disable         <= 1'b0;
         o_control_out_flush   <= 1'b0;
         o_control_in_flush    <= 1'b0;
         o_endpoint_flush_flag <= 1'b0;
      end else begin
         o_ep0_disable         <= i_evt.setup_rx;
         o_control_out_flush   <= i_evt.setup_rx;
         o_control_in_flush    <= i_evt.setup_rx;
         o_endpoint_flush_flag <= i_evt.setup_rx;
      end
   end

   // ******************************
   // Endpoint summary
   // ******************************
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_ep
         always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
               epsum_r[g] <= 1'b0;
            end else begin
               epsum_r[g] <= i_ep_irq_raw[g] & i_ep_irq_en[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_endpoint_irq_group <= UESR_ZERO8;
      end else begin
         o_endpoint_irq_group <= epsum_r;
      end
   end

   // ******************************
   // Read data
   // ******************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_rdata <= UESR_ZERO8;
      end else if (i_bus.rd) begin
         if (hit(i_bus.addr, UESR_OFF_THRESH)) begin
            o_rdata <= {4'h0, thresh_r};
         end else if (hit(i_bus.addr, UESR_OFF_BUSST)) begin
            o_rdata <= busst_r;
         end else if (hit(i_bus.addr, UESR_OFF_SRC)) begin
            o_rdata <= src_r;
         end else if (hit(i_bus.addr, UESR_OFF_EPSUM)) begin
            o_rdata <= epsum_r;
         end else begin
            o_rdata <= UESR_ZERO8;
         end
      end
   end

endmodule
`default_nettype wire

// ==== uesr_pkg.sv ====
package uesr_pkg;

   // ******************************
   // Register offsets
   // ******************************
   localparam logic [15:0] UESR_OFF_THRESH = 16'h2C03;
   localparam logic [15:0] UESR_OFF_BUSST  = 16'h2C08;
   localparam logic [15:0] UESR_OFF_SRC    = 16'h2C0A;
   localparam logic [15:0] UESR_OFF_EPSUM  = 16'h2C0C;

   // ******************************
   // Reset values and fields
   // ******************************
   localparam logic [3:0] UESR_THRESH_RST = 4'h3;
   localparam logic [7:0] UESR_ZERO8      = 8'h00;
   localparam int UESR_BUSRST_BIT  = 0;
   localparam int UESR_HALT_BIT    = 6;
   localparam int UESR_CONF_BIT    = 5;
   localparam int UESR_SUSP_BIT    = 4;
   localparam int UESR_INTF_BIT    = 3;
   localparam int UESR_SETUP_BIT   = 2;
   localparam logic [7:0] UESR_SRC_MASK = 8'h7C;

   // ******************************
   // Timing
   // ******************************
   localparam int UESR_CLK_HZ       = 25000000;
   localparam int UESR_IDLE_MS      = 3;
   localparam int UESR_SUSP_MS      = 2;
   localparam int UESR_IDLE_CYC     = UESR_CLK_HZ / 1000 * UESR_IDLE_MS;
   localparam int UESR_SUSP_CYC     = UESR_CLK_HZ / 1000 * UESR_SUSP_MS;
   localparam int UESR_TMR_W        = 17;

   // ******************************
   // Carriers
   // ******************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } uesr_bus_req_type;

   typedef struct packed {
      logic halt_clear;
      logic config_set;
      logic intf_set;
      logic setup_rx;
      logic bus_reset;
   } uesr_evt_type;

   typedef enum logic [1:0] {
      UESR_ST_ACTIVE = 2'b00,
      UESR_ST_IDLE   = 2'b01,
      UESR_ST_WAIT   = 2'b10,
      UESR_ST_SUSP   = 2'b11
   } uesr_susp_type;

endpackage

// ==== uesr_suspend_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module uesr_suspend_timer
   import uesr_pkg::*;
#(
   parameter int IDLE_CYC = UESR_IDLE_CYC,
   parameter int SUSP_CYC = UESR_SUSP_CYC
) (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_sys_rst,
   // Line state
   input  wire logic i_bus_idle,
   // Results
   output logic      o_phy_fs,
   output logic      o_suspend_pulse
);

   uesr_susp_type           state_r;
   logic [UESR_TMR_W-1:0]   cnt_r;

   // ******************************
   // Idle and suspend timing
   // ******************************
   always_ff @(posedge i_clk_sys) begin
      o_suspend_pulse <= 1'b0;
      if (i_sys_rst) begin
         state_r  <= UESR_ST_ACTIVE;
         cnt_r    <= '0;
         o_phy_fs <= 1'b0;
      end else if (!i_bus_idle) begin
         state_r  <= UESR_ST_ACTIVE;
         cnt_r    <= '0;
         o_phy_fs <= 1'b0;
      end else begin
         case (state_r)
            UESR_ST_ACTIVE: begin
               state_r <= UESR_ST_IDLE;
               cnt_r   <= UESR_TMR_W'(1);
            end
            UESR_ST_IDLE: begin
               if (cnt_r >= UESR_TMR_W'(IDLE_CYC)) begin
                  state_r  <= UESR_ST_WAIT;
                  o_phy_fs <= 1'b1;
                  cnt_r    <= UESR_TMR_W'(1);
               end else begin
                  cnt_r <= cnt_r + UESR_TMR_W'(1);
               end
            end
            UESR_ST_WAIT: begin
               if (cnt_r >= UESR_TMR_W'(SUSP_CYC)) begin
                  state_r         <= UESR_ST_SUSP;
                  o_suspend_pulse <= 1'b1;
               end else begin
                  cnt_r <= cnt_r + UESR_TMR_W'(1);
               end
            end
            UESR_ST_SUSP: begin
               state_r <= UESR_ST_SUSP;
            end
            default: begin
               state_r <= UESR_ST_ACTIVE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== uesr_irq_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module uesr_irq_ctrl_model (
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_sys_rst,
   // Flag lines and mask
   input  wire logic [7:0] i_lines,
   input  wire logic [7:0] i_mask,
   output logic            o_irq
);
   // Masking of the source flags lives only here, so those flags stay visible to software
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(i_lines & ~i_mask);
      end
   end
endmodule
`default_nettype wire

// ==== uesr_status_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module uesr_status_regs_chk
   import uesr_pkg::*;
(
   input wire logic         i_clk_sys,
   input wire logic         i_sys_rst,
   input wire uesr_evt_type i_evt,
   input wire logic         i_core_reset,
   input wire logic         i_bus_status_mask,
   input wire logic [7:0]   i_ep_irq_raw,
   input wire logic [7:0]   i_ep_irq_en,
   input wire logic         o_ep0_disable,
   input wire logic         o_control_out_flush,
   input wire logic         o_control_in_flush,
   input wire logic         o_endpoint_flush_flag,
   input wire logic         o_top_bus_status,
   input wire logic [7:0]   o_src_irq,
   input wire logic [7:0]   o_endpoint_irq_group
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   property p_setup; i_evt.setup_rx && !o_src_irq[2] |=> o_src_irq[UESR_SETUP_BIT]; endproperty
   a_setup: assert property (p_setup) else $error("setup flag missing");
   property p_dup; i_evt.setup_rx && o_src_irq[2] |=> !o_src_irq[2] ##1 o_src_irq[2]; endproperty
   a_dup: assert property (p_dup) else $error("repeat setup not signalled");
   property p_flush;
      i_evt.setup_rx |=> o_ep0_disable && o_control_out_flush && o_control_in_flush
         && o_endpoint_flush_flag;
   endproperty
   a_flush: assert property (p_flush) else $error("setup did not flush");
   property p_halt; i_evt.halt_clear |=> o_src_irq[UESR_HALT_BIT]; endproperty
   a_halt: assert property (p_halt) else $error("halt flag missing");
   property p_conf; i_evt.config_set |=> o_src_irq[UESR_CONF_BIT]; endproperty
   a_conf: assert property (p_conf) else $error("config flag missing");
   property p_intf; i_evt.intf_set |=> o_src_irq[UESR_INTF_BIT]; endproperty
   a_intf: assert property (p_intf) else $error("interface flag missing");
   property p_busrst;
      $fell(i_core_reset) ##1 !i_bus_status_mask |=> o_top_bus_status;
   endproperty
   a_busrst: assert property (p_busrst) else $error("bus reset summary missing");
   property p_ep;
      o_endpoint_irq_group == ($past(i_ep_irq_raw, 2) & $past(i_ep_irq_en, 2));
   endproperty
   a_ep: assert property (p_ep) else $error("endpoint summary wrong");
endmodule
bind uesr_status_regs uesr_status_regs_chk u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
   .i_evt(i_evt), .i_core_reset(i_core_reset), .i_bus_status_mask(i_bus_status_mask),
   .i_ep_irq_raw(i_ep_irq_raw), .i_ep_irq_en(i_ep_irq_en), .o_ep0_disable(o_ep0_disable),
   .o_control_out_flush(o_control_out_flush), .o_control_in_flush(o_control_in_flush),
   .o_endpoint_flush_flag(o_endpoint_flush_flag), .o_top_bus_status(o_top_bus_status),
   .o_src_irq(o_src_irq), .o_endpoint_irq_group(o_endpoint_irq_group));
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
   import uesr_pkg::*;
;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   uesr_bus_req_type bus = '0;
   uesr_evt_type     evt = '0;
   logic             core_rst = 1'b0;
   logic             idle = 1'b0;
   logic             msk = 1'b0;
   logic [7:0]       raw = 8'h00;
   logic [7:0]       en = 8'h00;
   logic [7:0]       imask = 8'h00;
   logic [4:0]       fre = 5'h00;
   logic [4:0]       len = 5'h00;
   logic             lst = 1'b0;
   logic [7:0]       rdata, src, grp;
   logic             pref, pfs, top, irq;
   int               err_count = 0;
   int               n_compared = 0;
   int               seed = 4174;
   int               cyc = 0;
   int               t, k;
   always #20 clk = ~clk;
   uesr_status_regs #(.IDLE_CYC(20), .SUSP_CYC(10)) dut (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_bus(bus), .o_rdata(rdata), .i_evt(evt), .i_core_reset(core_rst), .i_bus_idle(idle),
      .i_bus_status_mask(msk), .i_ep_irq_raw(raw), .i_ep_irq_en(en), .i_fifo_free_words(fre),
      .i_buf_len_words(len), .i_buf_last(lst), .o_prefetch_req(pref), .o_ep0_disable(),
      .o_control_out_flush(), .o_control_in_flush(), .o_endpoint_flush_flag(), .o_phy_fs(pfs),
      .o_top_bus_status(top), .o_src_irq(src), .o_endpoint_irq_group(grp));
   uesr_irq_ctrl_model u_ic (.i_clk_sys(clk), .i_sys_rst(rst), .i_lines(src), .i_mask(imask),
      .o_irq(irq));
   // ******************************
   // Expectations and bus cycles
   // ******************************
   function automatic logic exp_pref(input logic [3:0] th, input logic [4:0] f,
      input logic [4:0] n, input logic l);
      return (f >= th + 5'd1) || (l && n < th + 5'd1);
   endfunction
   function automatic logic [7:0] src_exp(input int i);
      int b [4] = '{UESR_HALT_BIT, UESR_CONF_BIT, UESR_INTF_BIT, UESR_SETUP_BIT};
      return 8'h01 << b[i];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) bus <= {2'b10, a, d};
      @(posedge clk) bus <= '0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk) bus <= {2'b01, a, 8'h00};
      @(posedge clk) bus <= '0;
      #1 chk(rdata, exp);
   endtask
   task automatic pulse(input uesr_evt_type e);
      @(posedge clk) evt <= e;
      @(posedge clk) evt <= '0;
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard, far above the roughly 500 cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         stop_test;
      end
   end
   // ******************************
   // Main sequence
   // ******************************
   initial begin
      t = $random(seed);
      imask <= t[7:0];
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rc(UESR_OFF_THRESH, 8'h03);
      rc(UESR_OFF_BUSST, 8'h00);
      rc(UESR_OFF_SRC, 8'h00);
      rc(UESR_OFF_EPSUM, 8'h00);
      rc(16'h2C04, 8'h00);
      wr(UESR_OFF_THRESH, 8'hFF);
      rc(UESR_OFF_THRESH, 8'h0F);
      for (k = 0; k < 40; k++) begin
         t = $random(seed);
         if (k == 0) t[14:0] = {1'b0, 5'd0, 5'd4, 4'd3};
         if (k == 1) t[14:0] = {1'b1, 5'd15, 5'd0, 4'hF};
         wr(UESR_OFF_THRESH, {4'h0, t[3:0]});
         fre <= t[8:4];
         len <= t[13:9];
         lst <= t[14];
         repeat (3) @(posedge clk);
         #1 chk({7'h00, pref}, {7'h00, exp_pref(t[3:0], t[8:4], t[13:9], t[14])});
      end
      for (k = 0; k < 4; k++) begin
         pulse(uesr_evt_type'(5'h10 >> k));
         rc(UESR_OFF_SRC, src_exp(k));
         chk({7'h00, irq}, {7'h00, |(src_exp(k) & ~imask)});
         wr(UESR_OFF_SRC, ~src_exp(k));
         rc(UESR_OFF_SRC, src_exp(k));
         wr(UESR_OFF_SRC, src_exp(k));
         rc(UESR_OFF_SRC, 8'h00);
      end
      pulse(uesr_evt_type'(5'h02));
      pulse(uesr_evt_type'(5'h02));
      rc(UESR_OFF_SRC, 8'h04);
      wr(UESR_OFF_SRC, 8'h04);
      pulse(uesr_evt_type'(5'h10));
      @(posedge clk) bus <= {2'b10, UESR_OFF_SRC, 8'h40};
      evt <= uesr_evt_type'(5'h10);
      @(posedge clk) bus <= '0;
      evt <= '0;
      rc(UESR_OFF_SRC, 8'h40);
      wr(UESR_OFF_SRC, 8'h40);
      core_rst <= 1'b1;
      repeat (3) @(posedge clk);
      core_rst <= 1'b0;
      rc(UESR_OFF_BUSST, 8'h01);
      chk({7'h00, top}, 8'h01);
      @(posedge clk) msk <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, top}, 8'h00);
      @(posedge clk) msk <= 1'b0;
      wr(UESR_OFF_BUSST, 8'h01);
      rc(UESR_OFF_BUSST, 8'h00);
      @(posedge clk) idle <= 1'b1;
      #1;
      for (t = 0; t < 40 && pfs !== 1'b1; t++) #40;
      chk({7'h00, t >= 19 && t <= 24}, 8'h01);
      for (k = 0; k < 40 && src[UESR_SUSP_BIT] !== 1'b1; k++) #40;
      chk({7'h00, k >= 8 && k <= 13}, 8'h01);
      @(posedge clk) idle <= 1'b0;
      for (k = 0; k < 20; k++) begin
         t = $random(seed);
         @(posedge clk);
         raw <= t[7:0];
         en <= t[15:8];
         repeat (3) @(posedge clk);
         #1 chk(grp, t[7:0] & t[15:8]);
         wr(UESR_OFF_EPSUM, 8'hFF);
         rc(UESR_OFF_EPSUM, t[7:0] & t[15:8]);
      end
      stop_test;
   end
endmodule
`default_nettype wire
